// >>> design/wake_frame_pattern_detector.sv
`timescale 1ns/1ps
`default_nettype none
module wake_frame_pattern_detector #(
    parameter int unsigned SLOTS = wake_pkg::SLOTS,
    parameter int unsigned MASK_BYTES = wake_pkg::MASK_BYTES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [wake_pkg::ADDR_W-1:0] addr_i,
    input wire logic [wake_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [wake_pkg::DATA_W-1:0] rdata_o,
    // Receive path
    input wire wake_pkg::rx_beat_s rx_i,
    input wire logic [47:0] station_addr_i,
    // Interrupt
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // Address helpers
    function automatic logic hit(input logic [wake_pkg::ADDR_W-1:0] a,
                                 input logic [3:0] bank, input logic [3:0] ofs);
        return (a[wake_pkg::ADDR_W-1:wake_pkg::BANK_LSB] == bank)
            && (a[wake_pkg::BANK_LSB-1:0] == ofs);
    endfunction : hit

    logic [15:0] ctrl_q; // Enables
    logic [15:0] status_q; // Sticky events, same layout as control
    logic [15:0] status_d;
    logic [15:0] irq_mask_q; // Interrupt mask, same layout
    logic [15:0] events; // One-cycle event vector
    logic [SLOTS-1:0][31:0] crc_all; // Expected CRCs of every slot
    logic [SLOTS-1:0][MASK_BYTES-1:0] mask_all; // Masks of every slot
    logic [SLOTS-1:0] match; // Slot match pulses
    logic remote_hit; // Remote-wake frame seen
    logic [15:0] rd_d;

    ////////////////////////////////////////////////////////////////////////
    // Control register, only enable bits writable
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= wake_pkg::REG_RESET;
        end else if (wr_i && hit(addr_i, wake_pkg::BANK_CTRL, wake_pkg::OFS_CTRL)) begin
            ctrl_q <= wdata_i & wake_pkg::CTRL_WR_MASK;
        end
    end

    // Interrupt mask register
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_mask_q <= wake_pkg::REG_RESET;
        end else if (wr_i && hit(addr_i, wake_pkg::BANK_CTRL, wake_pkg::OFS_IRQ_MASK)) begin
            irq_mask_q <= wdata_i & wake_pkg::CTRL_WR_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-slot bank: CRC halves, four mask words, CRC engine
    for (genvar i = 0; i < SLOTS; i++) begin : g_slot
        localparam logic [3:0] BANK = wake_pkg::BANK_SLOT0 + 4'(i);
        logic [31:0] crc_q;
        logic [MASK_BYTES-1:0] mask_q;

        // Expected CRC, low and high halves
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                crc_q <= {2{wake_pkg::REG_RESET}};
            end else if (wr_i && hit(addr_i, BANK, wake_pkg::OFS_CRC_LOW)) begin
                crc_q[15:0] <= wdata_i;
            end else if (wr_i && hit(addr_i, BANK, wake_pkg::OFS_CRC_HIGH)) begin
                crc_q[31:16] <= wdata_i;
            end
        end

        // Mask words, word k covers bytes 16k+1 to 16k+16
        for (genvar k = 0; k < wake_pkg::MASK_WORDS; k++) begin : g_word
            localparam logic [3:0] OFS = wake_pkg::OFS_MASK_W0 + 4'(2 * k);
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    mask_q[16*k+:16] <= wake_pkg::REG_RESET;
                end else if (wr_i && hit(addr_i, BANK, OFS)) begin
                    mask_q[16*k+:16] <= wdata_i;
                end
            end
        end

        assign crc_all[i] = crc_q;
        assign mask_all[i] = mask_q;

        // CRC engine of this slot
        wake_slot_crc #(
            .MASK_BYTES(MASK_BYTES)
        ) u_crc (
            .mclk_i(mclk_i),
            .resetn_i(resetn_i),
            .rx_i(rx_i),
            .enable_i(ctrl_q[i]),
            .mask_i(mask_q),
            .expect_i(crc_q),
            .match_o(match[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Remote-wake search: six sync bytes, then sixteen station addresses
    wake_pkg::remote_e rw_q;
    logic [2:0] sync_cnt_q; // Sync bytes seen
    logic [6:0] addr_cnt_q; // Address bytes matched
    logic [2:0] sta_idx_q; // Byte position within the station address
    logic found_q; // Pattern complete in this frame
    logic [7:0] sta_byte; // Expected station byte

    // Station address goes out most significant byte first
    always_comb begin
        sta_byte = station_addr_i[8*(wake_pkg::STATION_LEN-3'h1-sta_idx_q)+:8];
    end

    // Search state machine
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rw_q <= wake_pkg::RW_HUNT;
            sync_cnt_q <= 3'h0;
            addr_cnt_q <= 7'h00;
            sta_idx_q <= 3'h0;
            found_q <= 1'b0;
        end else if (rx_i.valid) begin
            if (rx_i.first) begin
                // New frame: restart the search
                found_q <= 1'b0;
            end
            unique case (rw_q)
                wake_pkg::RW_HUNT: begin
                    // Wait for a first sync byte
                    if (rx_i.data == wake_pkg::SYNC_BYTE) begin
                        rw_q <= wake_pkg::RW_SYNC;
                        sync_cnt_q <= 3'h1;
                    end
                end
                wake_pkg::RW_SYNC: begin
                    // Count sync bytes, start address on the sixth
                    if (rx_i.data != wake_pkg::SYNC_BYTE) begin
                        rw_q <= wake_pkg::RW_HUNT;
                    end else if (sync_cnt_q == wake_pkg::SYNC_LEN - 3'h1) begin
                        rw_q <= wake_pkg::RW_ADDR;
                        addr_cnt_q <= 7'h00;
                        sta_idx_q <= 3'h0;
                    end else begin
                        sync_cnt_q <= sync_cnt_q + 3'h1;
                    end
                end
                wake_pkg::RW_ADDR: begin
                    // Match address bytes in turn
                    if (rx_i.data != sta_byte) begin
                        rw_q <= wake_pkg::RW_HUNT;
                    end else if (addr_cnt_q == wake_pkg::ADDR_LEN - 7'h01) begin
                        rw_q <= wake_pkg::RW_HUNT;
                        found_q <= 1'b1;
                    end else begin
                        addr_cnt_q <= addr_cnt_q + 7'h01;
                        sta_idx_q <= (sta_idx_q == wake_pkg::STATION_LEN - 3'h1)
                            ? 3'h0 : sta_idx_q + 3'h1;
                    end
                end
                default: begin
                    rw_q <= wake_pkg::RW_HUNT;
                end
            endcase
            if (rx_i.last) begin
                // Frame over: drop any partial pattern
                rw_q <= wake_pkg::RW_HUNT;
            end
        end
    end

    // Remote-wake event at frame end, only while enabled
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remote_hit <= 1'b0;
        end else begin
            remote_hit <= rx_i.valid && rx_i.last && found_q
                && ctrl_q[wake_pkg::REMOTE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, status and interrupt
    always_comb begin
        events = '0;
        events[SLOTS-1:0] = match;
        events[wake_pkg::REMOTE_BIT] = remote_hit;
        status_d = status_q;
        if (wr_i && hit(addr_i, wake_pkg::BANK_CTRL, wake_pkg::OFS_STATUS)) begin
            status_d = status_q & ~wdata_i; // Write one to clear
        end
        status_d = status_d | events; // Set beats clear
    end

    // Sticky status
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_q <= wake_pkg::REG_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_d & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode, unmapped reads return zero
    logic [3:0] rd_bank;
    logic [3:0] rd_slot;
    always_comb begin
        rd_bank = addr_i[wake_pkg::ADDR_W-1:wake_pkg::BANK_LSB];
        rd_slot = rd_bank - wake_pkg::BANK_SLOT0;
        rd_d = '0;
        if (rd_bank == wake_pkg::BANK_CTRL) begin
            unique case (addr_i[wake_pkg::BANK_LSB-1:0])
                wake_pkg::OFS_CTRL: rd_d = ctrl_q;
                wake_pkg::OFS_STATUS: rd_d = status_q;
                wake_pkg::OFS_IRQ_MASK: rd_d = irq_mask_q;
                default: rd_d = '0;
            endcase
        end else if (rd_bank >= wake_pkg::BANK_SLOT0 && rd_slot < 4'(SLOTS)) begin
            unique case (addr_i[wake_pkg::BANK_LSB-1:0])
                wake_pkg::OFS_CRC_LOW: rd_d = crc_all[rd_slot[1:0]][15:0];
                wake_pkg::OFS_CRC_HIGH: rd_d = crc_all[rd_slot[1:0]][31:16];
                wake_pkg::OFS_MASK_W0: rd_d = mask_all[rd_slot[1:0]][15:0];
                wake_pkg::OFS_MASK_W1: rd_d = mask_all[rd_slot[1:0]][31:16];
                wake_pkg::OFS_MASK_W2: rd_d = mask_all[rd_slot[1:0]][47:32];
                wake_pkg::OFS_MASK_W3: rd_d = mask_all[rd_slot[1:0]][63:48];
                default: rd_d = '0;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rd_i ? rd_d : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic after_rst_q; // High on the first edge after reset release
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            after_rst_q <= 1'b1;
        end else begin
            after_rst_q <= 1'b0;
        end
    end

    AST_RESET_CLEAR: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        after_rst_q |-> ctrl_q == '0 && crc_all[0] == '0 && mask_all[SLOTS-1] == '0)
        else $error("configuration not zero after reset");
    AST_REMOTE_GATE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        remote_hit |-> $past(ctrl_q[wake_pkg::REMOTE_BIT]))
        else $error("remote event while disabled");
    AST_CTRL_RSVD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        rd_i && hit(addr_i, wake_pkg::BANK_CTRL, wake_pkg::OFS_CTRL)
        |=> rdata_o == $past(ctrl_q) && (rdata_o & ~wake_pkg::CTRL_WR_MASK) == '0)
        else $error("control read shows reserved bits");
    AST_CRC_HALF: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, wake_pkg::BANK_SLOT0, wake_pkg::OFS_CRC_HIGH)
        |=> crc_all[0][31:16] == $past(wdata_i) && $stable(crc_all[0][15:0]))
        else $error("crc high write wrong");
    AST_MASK_W0: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, wake_pkg::BANK_SLOT0, wake_pkg::OFS_MASK_W0)
        |=> mask_all[0][15:0] == $past(wdata_i))
        else $error("mask word 0 not bytes 1-16");
    AST_MASK_W1: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, wake_pkg::BANK_SLOT0, wake_pkg::OFS_MASK_W1)
        |=> mask_all[0][31:16] == $past(wdata_i))
        else $error("mask word 1 not bytes 17-32");
    AST_MASK_W2: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, wake_pkg::BANK_SLOT0, wake_pkg::OFS_MASK_W2)
        |=> mask_all[0][47:32] == $past(wdata_i))
        else $error("mask word 2 not bytes 33-48");
    AST_MASK_W3: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, wake_pkg::BANK_SLOT0, wake_pkg::OFS_MASK_W3)
        |=> mask_all[0][63:48] == $past(wdata_i) && $stable(ctrl_q))
        else $error("mask word 3 not bytes 49-64");
    AST_SLOT2_BANK: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, wake_pkg::BANK_SLOT0 + 4'h2, wake_pkg::OFS_CRC_LOW)
        |=> crc_all[2][15:0] == $past(wdata_i) && $stable(crc_all[0]))
        else $error("slot 2 bank write wrong");
    AST_SLOT1_MASK1: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_i && hit(addr_i, wake_pkg::BANK_SLOT0 + 4'h1, wake_pkg::OFS_MASK_W1)
        |=> mask_all[1][31:16] == $past(wdata_i))
        else $error("slot 1 mask word 1 wrong");
    AST_EVENT_STICKY: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        match[0] |=> status_q[0] ##1 (status_q[0] || $past(wr_i)))
        else $error("slot event not held in status");
endmodule : wake_frame_pattern_detector
`default_nettype wire

// >>> design/wake_pkg.sv
// Contract
// - Control bit 7 enables remote-wake detection.
// - Control bits 0-3 enable slots 0-3.
// - Slot CRC is 802.3 over masked bytes.
// - Expected CRC split low/high 16-bit registers.
// - Mask word 0 selects bytes 1-16.
// - Mask word 1 selects bytes 17-32.
// - Mask word 2 selects bytes 33-48.
// - Mask word 3 selects bytes 49-64.
// - Slot 2 has its own bank.
// - Slot 1 mask words 1-3 exist.
package wake_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BANK_LSB = 4;
    localparam int unsigned SLOTS = 4;
    localparam int unsigned MASK_BYTES = 64;
    localparam int unsigned MASK_WORDS = 4;
    // Banks: control bank, then one bank per slot
    localparam logic [3:0] BANK_CTRL = 4'h3;
    localparam logic [3:0] BANK_SLOT0 = 4'h4;
    // Offsets inside a bank
    localparam logic [3:0] OFS_CTRL = 4'ha;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    localparam logic [3:0] OFS_IRQ_MASK = 4'he;
    localparam logic [3:0] OFS_CRC_LOW = 4'h0;
    localparam logic [3:0] OFS_CRC_HIGH = 4'h2;
    localparam logic [3:0] OFS_MASK_W0 = 4'h4;
    localparam logic [3:0] OFS_MASK_W1 = 4'h6;
    localparam logic [3:0] OFS_MASK_W2 = 4'h8;
    localparam logic [3:0] OFS_MASK_W3 = 4'ha;
    // Control and status layout
    localparam int unsigned REMOTE_BIT = 7;
    localparam logic [15:0] CTRL_WR_MASK = 16'h008f;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Remote-wake packet shape
    localparam logic [7:0] SYNC_BYTE = 8'hff;
    localparam logic [2:0] SYNC_LEN = 3'h6;
    localparam logic [2:0] STATION_LEN = 3'h6;
    localparam logic [6:0] ADDR_LEN = 7'h60;
    // Ethernet CRC
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;

    // One received byte from the MAC receive path
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] data;
    } rx_beat_s;

    // Remote-wake search states
    typedef enum logic [2:0] {
        RW_HUNT = 3'b001,
        RW_SYNC = 3'b010,
        RW_ADDR = 3'b100
    } remote_e;

    // Reflected 802.3 CRC over one byte, LSB first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            r = ((r[0] ^ d[b]) == 1'b1) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte
endpackage : wake_pkg

// >>> design/wake_slot_crc.sv
`timescale 1ns/1ps
`default_nettype none
module wake_slot_crc #(
    parameter int unsigned MASK_BYTES = wake_pkg::MASK_BYTES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Receive bytes
    input wire wake_pkg::rx_beat_s rx_i,
    // Slot setup
    input wire logic enable_i,
    input wire logic [MASK_BYTES-1:0] mask_i,
    input wire logic [31:0] expect_i,
    // One-cycle match pulse
    output logic match_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [6:0] idx_q; // Next frame byte index, saturates at window end
    logic [31:0] crc_q; // Running CRC
    logic [6:0] cur_idx; // Index of the present byte
    logic in_win; // Byte lies inside the mask window
    logic sel; // Byte is covered by the mask
    logic [31:0] base; // CRC before this byte
    logic [31:0] crc_nx; // CRC after this byte

    // Byte selection: bit n of the mask picks frame byte n+1
    always_comb begin
        cur_idx = rx_i.first ? 7'h00 : idx_q;
        in_win = cur_idx < 7'(MASK_BYTES);
        sel = in_win && mask_i[cur_idx[5:0]];
        base = rx_i.first ? wake_pkg::CRC_INIT : crc_q;
        crc_nx = sel ? wake_pkg::crc_byte(base, rx_i.data) : base;
    end

    // Running CRC and byte index
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idx_q <= 7'h00;
            crc_q <= wake_pkg::CRC_INIT;
        end else if (rx_i.valid) begin
            crc_q <= crc_nx;
            idx_q <= in_win ? cur_idx + 7'h01 : cur_idx;
        end
    end

    // Frame-end compare against the complemented CRC
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            match_o <= 1'b0;
        end else begin
            match_o <= rx_i.valid && rx_i.last && enable_i
                && ((~crc_nx) == expect_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unselected bytes leave the CRC alone
    AST_CRC_SKIP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        rx_i.valid && !rx_i.first && !sel |=> crc_q == $past(crc_q))
        else $error("crc moved on an unselected byte");
    // Bytes past the window never count
    AST_WINDOW_END: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        rx_i.valid && !rx_i.first && idx_q == 7'(MASK_BYTES) |=> crc_q == $past(crc_q))
        else $error("byte beyond window entered crc");
    // A match needs the enable and a frame end
    AST_MATCH_CAUSE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        match_o |-> $past(enable_i) && $past(rx_i.valid) && $past(rx_i.last))
        else $error("match without enabled frame end");
endmodule : wake_slot_crc
`default_nettype wire

// >>> verification/mac_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Receive-path stand-in: plays whole frames, one byte per beat
module mac_rx_model (
    // Clock
    input wire logic mclk_i,
    // Beats toward the detector
    output var wake_pkg::rx_beat_s rx_o
);
    // Idle at start
    initial rx_o = '0;

    // Idle beat after every fifth byte; idle data never repeats the last byte
    task automatic send(input logic [7:0] f[], input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk_i);
            rx_o <= '{valid: 1'b1, first: (i == 0), last: (i == n - 1), data: f[i]};
            if (i % 5 == 4 && i != n - 1) begin
                @(posedge mclk_i);
                rx_o <= '{valid: 1'b0, first: 1'b0, last: 1'b0, data: ~f[i]};
            end
        end
        @(posedge mclk_i);
        rx_o <= '{valid: 1'b0, first: 1'b0, last: 1'b0, data: ~f[n - 1]};
    endtask : send
endmodule : mac_rx_model
`default_nettype wire

// >>> verification/wake_frame_pattern_detector_test.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Register and wake-frame checks
module wake_frame_pattern_detector_test;
    logic mclk_i;
    logic resetn_i;
    logic [7:0] addr_i;
    logic [15:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [15:0] rdata_o;
    logic irq_o;
    wake_pkg::rx_beat_s rx_w; // Beats from the model
    logic [47:0] station_addr_i;
    int bad_count;
    int samples_checked;
    logic [7:0] frame [];

    wake_frame_pattern_detector u_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_w),
        .station_addr_i(station_addr_i), .irq_o(irq_o)
    );
    mac_rx_model u_rx (.mclk_i(mclk_i), .rx_o(rx_w));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One-cycle write
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    // One-cycle read, data sampled in the following cycle
    task automatic expect_reg(input string name, input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 check(name, 32'(rdata_o), 32'(e));
    endtask : expect_reg

    // Reference 802.3 CRC over the selected bytes, complemented
    function automatic logic [31:0] ref_crc(input logic [63:0] m);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = 0; i < 64; i++) begin
            if (m[i]) begin
                for (int b = 0; b < 8; b++) begin
                    c = (c[0] ^ frame[i][b]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
                end
            end
        end
        return ~c;
    endfunction : ref_crc

    // Send frame, check status and irq, clear status
    task automatic play(input logic [15:0] st, input logic irq);
        u_rx.send(frame, frame.size());
        repeat (3) @(posedge mclk_i);
        expect_reg("status", 8'h3c, st);
        check("irq", 32'(irq_o), 32'(irq));
        wr_reg(8'h3c, 16'h00ff);
    endtask : play

    // Verdict
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [63:0] m;
        logic [31:0] c;
        resetn_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        station_addr_i = 48'h02a4c6e8f0b3;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        for (int a = 8'h3a; a < 8'h80; a += 2) expect_reg("reset", a[7:0], 16'h0000);
        check("irq", 32'(irq_o), 32'h0);
        $display("test reset done");
        // Control keeps only enable bits; unmapped space ignored
        wr_reg(8'h3a, 16'hffff);
        expect_reg("control", 8'h3a, 16'h008f);
        wr_reg(8'h20, 16'h1234);
        expect_reg("unmapped", 8'h20, 16'h0000);
        wr_reg(8'h3a, 16'h0000);
        wr_reg(8'h3e, 16'h00ff);
        // Slot n selects bits 0,5,10,15 of mask word n
        frame = new[70];
        foreach (frame[i]) frame[i] = 8'(i * 37 + 11);
        for (int n = 0; n < 4; n++) begin
            m = 64'h8421 << (16 * n);
            c = ref_crc(m);
            wr_reg({4'(4 + n), 4'h0}, c[15:0]);
            wr_reg({4'(4 + n), 4'h2}, c[31:16]);
            for (int k = 0; k < 4; k++) wr_reg({4'(4 + n), 4'(4 + 2 * k)}, m[16 * k +: 16]);
            expect_reg("crc low", {4'(4 + n), 4'h0}, c[15:0]);
            expect_reg("crc high", {4'(4 + n), 4'h2}, c[31:16]);
            expect_reg("mask", {4'(4 + n), 4'(4 + 2 * n)}, 16'h8421);
        end
        $display("test registers done");
        // Each slot alone: match, unmasked byte changed, masked byte changed
        for (int n = 0; n < 4; n++) begin
            wr_reg(8'h3a, 16'(1 << n));
            play(16'(1 << n), 1'b1);
            frame[16 * n + 1] ^= 8'h01;
            play(16'(1 << n), 1'b1);
            frame[16 * n + 15] ^= 8'h01;
            play(16'h0000, 1'b0);
            frame[16 * n + 1] ^= 8'h01;
            frame[16 * n + 15] ^= 8'h01;
        end
        wr_reg(8'h3a, 16'h0000);
        play(16'h0000, 1'b0);
        $display("test slots done");
        // Masked interrupt, then unmasked, then cleared
        wr_reg(8'h3e, 16'h0000);
        wr_reg(8'h3a, 16'h0001);
        play(16'h0001, 1'b0);
        u_rx.send(frame, frame.size());
        repeat (3) @(posedge mclk_i);
        wr_reg(8'h3e, 16'h00ff);
        repeat (2) @(posedge mclk_i);
        #1 check("irq on", 32'(irq_o), 32'h1);
        wr_reg(8'h3c, 16'h0001);
        repeat (2) @(posedge mclk_i);
        #1 check("irq off", 32'(irq_o), 32'h0);
        $display("test interrupt done");
        // Remote wake: sync run then 16 station copies
        frame = new[108];
        foreach (frame[i]) begin
            frame[i] = (i < 4) ? 8'h55 : (i < 10) ? 8'hff : 8'h00;
            if (i >= 10 && i < 106) frame[i] = station_addr_i[47 - 8 * ((i - 10) % 6) -: 8];
        end
        wr_reg(8'h3a, 16'h0080);
        play(16'h0080, 1'b1);
        wr_reg(8'h3a, 16'h0000);
        play(16'h0000, 1'b0);
        $display("test remote wake done");
        complete_run();
    end
endmodule : wake_frame_pattern_detector_test
`default_nettype wire
